// >>> hw/mrb_fifo.sv
// first-in first-out record buffer with a registered output stage
// assumes one clock; DEPTH is a power of two; clear_i flushes everything
`timescale 1ns/1ps
module mrb_fifo #(
  parameter int WIDTH = 128,
  parameter int DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic clear_i,
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  output logic full_o,
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] CNT_FULL = (AW+1)'(DEPTH);
  localparam logic [AW:0] CNT_ONE = (AW+1)'(1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] cnt;
  logic [AW:0] next_cnt;
  logic wr;
  logic rd;

  // write when not full; move a word to the output stage when it is free
  assign wr = in_valid_i && !full_o;
  assign rd = (cnt != '0) && (!out_valid_o || out_ready_i);
  assign in_ready_o = !full_o;

  always_comb begin
    next_cnt = cnt;
    if (wr && !rd) begin
      next_cnt = cnt + CNT_ONE;
    end else if (rd && !wr) begin
      next_cnt = cnt - CNT_ONE;
    end
  end

  // storage array, no reset needed
  always_ff @(posedge clk_i) begin
    if (wr) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  // pointers, fill count and full flag
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      cnt <= '0;
      full_o <= 1'b0;
    end else if (clear_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      cnt <= '0;
      full_o <= 1'b0;
    end else begin
      if (wr) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (rd) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      cnt <= next_cnt;
      full_o <= (next_cnt == CNT_FULL);
    end
  end

  // registered read data stage
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      out_valid_o <= 1'b0;
      out_data_o <= '0;
    end else if (clear_i) begin
      out_valid_o <= 1'b0;
    end else if (rd) begin
      out_valid_o <= 1'b1;
      out_data_o <= mem[rd_ptr];
    end else if (out_ready_i) begin
      out_valid_o <= 1'b0;
    end
  end

endmodule

// >>> hw/mrb_top.sv
// measurement record buffer: recording control, interval timer, trigger
// system and the record buffer of sample sets
// assumes settings arrive as plain ports loaded by cfg_write_i, commands are
// one-cycle pulses from logic on clk_i, and trigger_pin_i is asynchronous
//
// Operation
// (R1) Recording control set to always stores sample sets; set to off stores none.
// (R2) Buffer depth accepts 1 to 65536 points or the unlimited option and reads back.
// (R3) With the unlimited option recording goes on until the buffer is full.
// (R4) Interval is 0.4 us to 26.2 ms in 0.4 us steps, one sample set per interval.
// (R5) A latest-data query returns the newest sample set with unselected parameters cleared.
// (R6) An arm command moves the trigger system from idle to awaiting trigger.
// (R7) A full buffer during recording stops recording and returns the system to idle.
// (R8) While the buffer is full arming is refused; the host clears the buffer first.
// (R9) An arm while recording is off or the system is not idle is ignored.
`timescale 1ns/1ps
module mrb_top #(
  parameter int FIFO_DEPTH = mrb_pkg::FIFO_DEPTH,
  parameter int PARAMS = mrb_pkg::PARAM_COUNT,
  parameter int LANE_W = mrb_pkg::LANE_W,
  parameter int INTERVAL_MAX = mrb_pkg::INTERVAL_MAX_QUANTA
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic cfg_write_i,
  input wire logic record_control_i,
  input wire logic [mrb_pkg::DEPTH_W-1:0] depth_points_i,
  input wire logic unlimited_depth_option_i,
  input wire logic [mrb_pkg::INTERVAL_W-1:0] interval_quanta_i,
  input wire logic [PARAMS-1:0] param_select_i,
  input wire logic arm_trigger_command_i,
  input wire logic trigger_pin_i,
  input wire logic buffer_clear_i,
  input wire logic fetch_i,
  input wire logic [PARAMS*LANE_W-1:0] sample_data_i,
  input wire logic out_ready_i,
  output logic out_valid_o,
  output logic [PARAMS*LANE_W-1:0] out_data_o,
  output logic record_control_o,
  output logic [mrb_pkg::DEPTH_W-1:0] depth_points_o,
  output logic unlimited_depth_option_o,
  output logic [mrb_pkg::INTERVAL_W-1:0] interval_quanta_o,
  output logic [PARAMS-1:0] param_select_o,
  output mrb_pkg::mrb_trig_state_t trig_state_o,
  output logic buffer_full_o,
  output logic [mrb_pkg::DEPTH_W-1:0] points_recorded_o,
  output logic arm_refused_o,
  output logic fetch_valid_o,
  output logic [PARAMS*LANE_W-1:0] fetch_data_o
);
  import mrb_pkg::*;

  localparam logic [INTERVAL_W-1:0] INTERVAL_TOP = INTERVAL_W'(INTERVAL_MAX);
  localparam int SET_W = PARAMS * LANE_W;

  // clamp a requested depth into the legal point range
  function automatic logic [DEPTH_W-1:0] clamp_depth(input logic [DEPTH_W-1:0] req);
    logic [DEPTH_W-1:0] res;
    res = req;
    if (req < DEPTH_MIN) begin
      res = DEPTH_MIN;
    end else if (req > DEPTH_MAX) begin
      res = DEPTH_MAX;
    end
    return res;
  endfunction

  // clamp a requested interval into the legal quantum range
  function automatic logic [INTERVAL_W-1:0] clamp_interval(input logic [INTERVAL_W-1:0] req);
    logic [INTERVAL_W-1:0] res;
    res = req;
    if (req < INTERVAL_MIN) begin
      res = INTERVAL_MIN;
    end else if (req > INTERVAL_TOP) begin
      res = INTERVAL_TOP;
    end
    return res;
  endfunction

  mrb_trig_state_t state;
  mrb_trig_state_t next_state;
  logic [QCNT_W-1:0] qcnt;
  logic [INTERVAL_W-1:0] icnt;
  logic quantum_tick;
  logic sample_tick;
  logic trig_meta;
  logic trig_sync;
  logic trig_prev;
  logic trig_rise;
  logic arm_ok;
  logic push;
  logic fifo_ready;
  logic last_point;
  logic [SET_W-1:0] masked_set;
  logic [SET_W-1:0] latest;

  // settings registers, loaded together by a configuration write
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      record_control_o <= RECORD_OFF_CHOICE;
      depth_points_o <= DEPTH_RESET;
      unlimited_depth_option_o <= 1'b0;
      interval_quanta_o <= INTERVAL_RESET;
      param_select_o <= PARAM_SELECT_RESET;
    end else if (cfg_write_i) begin
      record_control_o <= record_control_i; // R1
      depth_points_o <= clamp_depth(depth_points_i); // R2
      unlimited_depth_option_o <= unlimited_depth_option_i; // R2
      interval_quanta_o <= clamp_interval(interval_quanta_i); // R4
      param_select_o <= param_select_i;
    end
  end

  // quantum prescaler: one tick every 0.4 us
  assign quantum_tick = (qcnt == QCNT_LAST);

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      qcnt <= '0;
    end else if (cfg_write_i || quantum_tick) begin
      qcnt <= '0; // R4
    end else begin
      qcnt <= qcnt + 1'b1;
    end
  end

  // interval counter: one sample set per programmed number of quanta
  assign sample_tick = quantum_tick && (icnt >= interval_quanta_o);

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      icnt <= INTERVAL_MIN;
    end else if (cfg_write_i || sample_tick) begin
      icnt <= INTERVAL_MIN; // R4
    end else if (quantum_tick) begin
      icnt <= icnt + 1'b1;
    end
  end

  // trigger pin synchroniser and rising edge detect
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      trig_meta <= 1'b0;
      trig_sync <= 1'b0;
      trig_prev <= 1'b0;
    end else begin
      trig_meta <= trigger_pin_i;
      trig_sync <= trig_meta;
      trig_prev <= trig_sync;
    end
  end

  assign trig_rise = trig_sync && !trig_prev;

  // sample set with unselected parameters cleared
  always_comb begin
    masked_set = '0;
    for (int i = 0; i < PARAMS; i++) begin
      if (param_select_o[i]) begin
        masked_set[i*LANE_W +: LANE_W] = sample_data_i[i*LANE_W +: LANE_W]; // R5
      end
    end
  end

  // newest sample set, refreshed every interval
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      latest <= '0;
    end else if (sample_tick) begin
      latest <= masked_set; // R5
    end
  end

  // latest-data query answer, one cycle after the request
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      fetch_valid_o <= 1'b0;
      fetch_data_o <= '0;
    end else begin
      fetch_valid_o <= fetch_i;
      if (fetch_i) begin
        fetch_data_o <= latest; // R5
      end
    end
  end

  // arming needs recording on, an idle system and room in the buffer
  assign arm_ok = arm_trigger_command_i && (state == TRIG_IDLE) // R6 R9
    && (record_control_o == RECORD_ALWAYS) // R9
    && !buffer_full_o; // R8

  // a set enters the buffer only while recording and not full
  assign push = (state == TRIG_RECORD) && sample_tick // R4
    && (record_control_o == RECORD_ALWAYS) // R1
    && fifo_ready; // R7

  // a bounded depth ends on the point that reaches the setting
  assign last_point = !unlimited_depth_option_o // R3
    && ((points_recorded_o + POINTS_ONE) >= depth_points_o); // R2

  // trigger system transitions
  always_comb begin
    next_state = state;
    unique case (state)
      TRIG_IDLE: begin
        if (arm_ok) begin
          next_state = TRIG_AWAIT; // R6
        end
      end
      TRIG_AWAIT: begin
        if (record_control_o != RECORD_ALWAYS) begin
          next_state = TRIG_IDLE; // R1
        end else if (buffer_full_o) begin
          next_state = TRIG_IDLE; // R8
        end else if (trig_rise) begin
          next_state = TRIG_RECORD;
        end
      end
      TRIG_RECORD: begin
        if (record_control_o != RECORD_ALWAYS) begin
          next_state = TRIG_IDLE; // R1
        end else if (buffer_full_o) begin
          next_state = TRIG_IDLE; // R3 R7
        end else if (push && last_point) begin
          next_state = TRIG_IDLE; // R2
        end
      end
      default: begin
        next_state = TRIG_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state <= TRIG_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // visible trigger state
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      trig_state_o <= TRIG_IDLE;
    end else begin
      trig_state_o <= next_state;
    end
  end

  // refused arm reported as a one-cycle pulse; state stays as it was
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      arm_refused_o <= 1'b0;
    end else begin
      arm_refused_o <= arm_trigger_command_i && !arm_ok; // R8 R9
    end
  end

  // points stored since the last arm
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      points_recorded_o <= '0;
    end else if (arm_ok) begin
      points_recorded_o <= '0;
    end else if (push) begin
      points_recorded_o <= points_recorded_o + POINTS_ONE;
    end
  end

  // measurement record buffer
  mrb_fifo #(
    .WIDTH(SET_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .clear_i(buffer_clear_i),
    .in_valid_i(push),
    .in_data_i(masked_set),
    .in_ready_o(fifo_ready),
    .full_o(buffer_full_o),
    .out_valid_o(out_valid_o),
    .out_data_o(out_data_o),
    .out_ready_i(out_ready_i)
  );

endmodule

// >>> shared/mrb_pkg.sv
// constants and types shared by the measurement record buffer files
// assumes a 50 MHz system clock; all timing counts derive from it
package mrb_pkg;

  // clock and interval quantum
  localparam int CLK_PERIOD_NS = 20;
  localparam int QUANTUM_NS = 400;
  // least time: round up to whole cycles
  localparam int QUANTUM_CYCLES = (QUANTUM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int QCNT_W = $clog2(QUANTUM_CYCLES);
  localparam logic [QCNT_W-1:0] QCNT_LAST = QCNT_W'(QUANTUM_CYCLES - 1);

  // recording interval limits, in quanta
  localparam int INTERVAL_MAX_NS = 26_200_000;
  localparam int INTERVAL_MAX_QUANTA = INTERVAL_MAX_NS / QUANTUM_NS;
  localparam int INTERVAL_W = 16;
  localparam logic [INTERVAL_W-1:0] INTERVAL_MIN = 16'h0001;
  localparam logic [INTERVAL_W-1:0] INTERVAL_RESET = 16'h0001;

  // buffer depth setting, in points
  localparam int DEPTH_W = 17;
  localparam logic [DEPTH_W-1:0] DEPTH_MIN = 17'h00001;
  localparam logic [DEPTH_W-1:0] DEPTH_MAX = 17'h10000;
  localparam logic [DEPTH_W-1:0] DEPTH_RESET = 17'h10000;
  localparam logic [DEPTH_W-1:0] POINTS_ONE = 17'h00001;

  // sample set layout and record buffer size
  localparam int PARAM_COUNT = 8;
  localparam int LANE_W = 16;
  localparam int FIFO_DEPTH = 16;

  // recording control choices
  localparam logic RECORD_ALWAYS = 1'b1;
  localparam logic RECORD_OFF_CHOICE = 1'b0;
  localparam logic [PARAM_COUNT-1:0] PARAM_SELECT_RESET = 8'hFF;

  // trigger system states, one-hot
  typedef enum logic [2:0] {
    TRIG_IDLE = 3'b001,
    TRIG_AWAIT = 3'b010,
    TRIG_RECORD = 3'b100
  } mrb_trig_state_t;

endpackage

// >>> sim/mrb_checker.sv
// assertions on the record buffer top-level ports
// assumes one clock and the active-low asynchronous reset
`timescale 1ns/1ps
module mrb_checker (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic cfg_write_i,
  input wire logic [mrb_pkg::DEPTH_W-1:0] depth_points_i,
  input wire logic arm_trigger_command_i,
  input wire logic trigger_pin_i,
  input wire logic fetch_i,
  input wire logic record_control_o,
  input wire logic [mrb_pkg::DEPTH_W-1:0] depth_points_o,
  input wire logic unlimited_depth_option_o,
  input wire mrb_pkg::mrb_trig_state_t trig_state_o,
  input wire logic buffer_full_o,
  input wire logic [mrb_pkg::DEPTH_W-1:0] points_recorded_o,
  input wire logic arm_refused_o,
  input wire logic fetch_valid_o
);
  import mrb_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  // an arm that finds the system ready
  sequence s_arm_ok;
    arm_trigger_command_i && trig_state_o == TRIG_IDLE && record_control_o && !buffer_full_o;
  endsequence
  // a pin edge while awaiting
  sequence s_pin_rise;
    trig_state_o == TRIG_AWAIT && $rose(trigger_pin_i);
  endsequence
  AST_ARM_ACCEPT:
    assert property (s_arm_ok |=> trig_state_o == TRIG_AWAIT && points_recorded_o == '0)
    else $error("arm not accepted");
  AST_ARM_REFUSE:
    assert property (arm_trigger_command_i && trig_state_o == TRIG_IDLE && !record_control_o
      |=> arm_refused_o && trig_state_o == TRIG_IDLE)
    else $error("arm while off not ignored");
  AST_FULL_NO_ARM:
    assert property (arm_trigger_command_i && buffer_full_o && trig_state_o == TRIG_IDLE
      |=> arm_refused_o && trig_state_o == TRIG_IDLE)
    else $error("arm accepted while full");
  AST_FULL_IDLE:
    assert property (trig_state_o == TRIG_RECORD && buffer_full_o |=> trig_state_o == TRIG_IDLE)
    else $error("recording went on while full");
  AST_OFF_HOLD:
    assert property (!record_control_o |=> $stable(points_recorded_o))
    else $error("points moved while recording off");
  AST_DEPTH_STOP:
    assert property (!unlimited_depth_option_o && trig_state_o == TRIG_RECORD
      |-> points_recorded_o < depth_points_o)
    else $error("recording beyond depth");
  AST_DEPTH_BACK:
    assert property (cfg_write_i && depth_points_i != '0 && depth_points_i <= DEPTH_MAX
      |=> depth_points_o == $past(depth_points_i))
    else $error("depth readback wrong");
  AST_PIN_RECORD:
    assert property (s_pin_rise |-> ##[1:6] trig_state_o == TRIG_RECORD)
    else $error("trigger edge did not start recording");
  AST_FETCH_ONE:
    assert property (fetch_i |=> fetch_valid_o ##1 fetch_valid_o == $past(fetch_i))
    else $error("fetch answer not a single pulse");
endmodule
bind mrb_top mrb_checker u_chk (.clk_i, .arst_n_i, .cfg_write_i, .depth_points_i,
  .arm_trigger_command_i, .trigger_pin_i, .fetch_i, .record_control_o, .depth_points_o,
  .unlimited_depth_option_o, .trig_state_o, .buffer_full_o, .points_recorded_o,
  .arm_refused_o, .fetch_valid_o);

// >>> sim/mrb_drain_model.sv
// drain-side model taking words off the record buffer output
// assumes valid/ready on clk_i; slow_i makes ready every other cycle
`timescale 1ns/1ps
module mrb_drain_model #(
  parameter int WIDTH = 128
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic stall_i,
  input wire logic slow_i,
  input wire logic valid_i,
  input wire logic [WIDTH-1:0] data_i,
  output logic ready_o
);
  logic [WIDTH-1:0] got_q[$];
  // ready changes just after the edge
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ready_o <= 1'b0;
    end else begin
      ready_o <= ~stall_i & (~slow_i | ~ready_o);
    end
  end
  // collect each word taken at a handshake edge
  always @(posedge clk_i) begin
    if (arst_n_i && valid_i && ready_o) begin
      got_q.push_back(data_i);
    end
  end
endmodule

// >>> sim/test_measurement_record_buffer.sv
// self-checking bench for the measurement record buffer
// assumes mrb_pkg, the drain model and the bound checker are compiled first
`timescale 1ns/1ps
module test_measurement_record_buffer;
  import mrb_pkg::*;
  localparam int W = PARAM_COUNT * LANE_W;
  localparam int IMAX = 4;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic cfg_write_i = 1'b0;
  logic record_control_i = 1'b0;
  logic [DEPTH_W-1:0] depth_points_i = '0;
  logic unlimited_depth_option_i = 1'b0;
  logic [INTERVAL_W-1:0] interval_quanta_i = '0;
  logic [PARAM_COUNT-1:0] param_select_i = '0;
  logic arm_trigger_command_i = 1'b0;
  logic trigger_pin_i = 1'b0;
  logic buffer_clear_i = 1'b0;
  logic fetch_i = 1'b0;
  logic [W-1:0] sample_data_i = '0;
  logic out_ready_i, out_valid_o, record_control_o, unlimited_depth_option_o;
  logic buffer_full_o, arm_refused_o, fetch_valid_o;
  logic [W-1:0] out_data_o, fetch_data_o;
  logic [DEPTH_W-1:0] depth_points_o, points_recorded_o;
  logic [INTERVAL_W-1:0] interval_quanta_o;
  logic [PARAM_COUNT-1:0] param_select_o;
  mrb_trig_state_t trig_state_o;
  logic stall = 1'b1;
  logic slow = 1'b0;
  int fail_count = 0;
  int num_checks = 0;
  int cnt, per, npts, depth, n;
  bit run = 0;
  bit timed = 0;
  logic [W-1:0] latest = '0;
  logic [W-1:0] mask = '0;
  logic [W-1:0] snap;
  logic [W-1:0] exp_q[$];
  mrb_top #(.INTERVAL_MAX(IMAX)) u_dut (.clk_i, .arst_n_i, .cfg_write_i, .record_control_i,
    .depth_points_i, .unlimited_depth_option_i, .interval_quanta_i, .param_select_i,
    .arm_trigger_command_i, .trigger_pin_i, .buffer_clear_i, .fetch_i, .sample_data_i,
    .out_ready_i, .out_valid_o, .out_data_o, .record_control_o, .depth_points_o,
    .unlimited_depth_option_o, .interval_quanta_o, .param_select_o, .trig_state_o,
    .buffer_full_o, .points_recorded_o, .arm_refused_o, .fetch_valid_o, .fetch_data_o);
  mrb_drain_model #(.WIDTH(W)) u_drain (.clk_i, .arst_n_i, .stall_i(stall), .slow_i(slow),
    .valid_i(out_valid_o), .data_i(out_data_o), .ready_o(out_ready_i));
  always #10 clk_i = ~clk_i;
  // fresh sample set every cycle
  always @(negedge clk_i) sample_data_i <= {$urandom, $urandom, $urandom, $urandom};
  // reference: interval ticks, latest set, pushes while recording
  always @(posedge clk_i) begin
    if (cfg_write_i) begin
      cnt = 0;
    end else if (timed) begin
      cnt++;
      if (cnt == per) begin
        cnt = 0;
        latest = sample_data_i & mask;
        if (run && npts < depth && exp_q.size() <= FIFO_DEPTH) begin
          exp_q.push_back(latest);
          npts++;
        end
        if (npts == depth || exp_q.size() > FIFO_DEPTH) run = 0;
      end
    end
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk_word(input string what, input logic [W-1:0] exp, input logic [W-1:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    chk_word(what, W'(exp), W'(got));
  endtask
  task automatic bail(input string what);
    fail_count++;
    $display("BAD %s expected done seen timeout", what);
    give_verdict();
  endtask
  task automatic wait_st(input logic [2:0] st, input int lim);
    for (n = 0; n < lim && trig_state_o !== st; n++) @(negedge clk_i);
    if (n == lim) bail("state wait");
  endtask
  task automatic wait_got(input int k);
    for (n = 0; n < 400 && u_drain.got_q.size() < k; n++) @(negedge clk_i);
    if (n == 400) bail("drain wait");
  endtask
  task automatic pulse(ref logic sig);
    @(negedge clk_i);
    snap = latest;
    sig = 1'b1;
    @(negedge clk_i);
    sig = 1'b0;
  endtask
  task automatic set_cfg(input logic rec, input logic [DEPTH_W-1:0] dep, input logic unl,
    input logic [INTERVAL_W-1:0] iv);
    @(negedge clk_i);
    record_control_i = rec;
    depth_points_i = dep;
    unlimited_depth_option_i = unl;
    interval_quanta_i = iv;
    param_select_i = PARAM_COUNT'($urandom);
    for (int i = 0; i < PARAM_COUNT; i++) mask[i*LANE_W+:LANE_W] = {LANE_W{param_select_i[i]}};
    per = (iv > IMAX ? IMAX : int'(iv)) * QUANTUM_CYCLES;
    depth = unl ? 1 << 30 : int'(dep);
    npts = 0;
    timed = 1'b1;
    cfg_write_i = 1'b1;
    @(negedge clk_i);
    cfg_write_i = 1'b0;
  endtask
  // drained words against the reference queue, in order
  task automatic cmp_q(input int k);
    chk_val("count", k, 32'(u_drain.got_q.size()));
    while (u_drain.got_q.size() > 0 && exp_q.size() > 0)
      chk_word("word", exp_q.pop_front(), u_drain.got_q.pop_front());
    exp_q = {};
  endtask
  // main sequence
  initial begin
    void'($urandom(4));
    repeat (5) @(negedge clk_i);
    arst_n_i = 1'b1;
    @(negedge clk_i);
    chk_val("depth", 32'(DEPTH_RESET), 32'(depth_points_o));
    chk_val("state", 32'(TRIG_IDLE), 32'(trig_state_o));
    $display("test reset done");
    set_cfg(RECORD_OFF_CHOICE, '0, 1'b0, 16'h0009);
    chk_val("depth", 32'(DEPTH_MIN), 32'(depth_points_o));
    chk_val("interval", IMAX, 32'(interval_quanta_o));
    chk_val("record", 32'(RECORD_OFF_CHOICE), 32'(record_control_o));
    pulse(arm_trigger_command_i);
    chk_val("refused", 1, 32'(arm_refused_o));
    chk_val("state", 32'(TRIG_IDLE), 32'(trig_state_o));
    $display("test record off done");
    stall = 1'b0;
    set_cfg(RECORD_ALWAYS, 17'h00003, 1'b0, 16'h0002);
    chk_val("depth", 3, 32'(depth_points_o));
    chk_val("select", 32'(param_select_i), 32'(param_select_o));
    pulse(arm_trigger_command_i);
    chk_val("state", 32'(TRIG_AWAIT), 32'(trig_state_o));
    pulse(arm_trigger_command_i);
    chk_val("refused", 1, 32'(arm_refused_o));
    trigger_pin_i = 1'b1;
    run = 1'b1;
    wait_st(TRIG_IDLE, 400);
    chk_val("points", 3, 32'(points_recorded_o));
    pulse(fetch_i);
    chk_word("fetch", snap, fetch_data_o);
    chk_val("fetch valid", 1, 32'(fetch_valid_o));
    wait_got(3);
    cmp_q(3);
    trigger_pin_i = 1'b0;
    $display("test bounded depth done");
    stall = 1'b1;
    set_cfg(RECORD_ALWAYS, 17'h00005, 1'b1, 16'h0001);
    chk_val("unlimited", 1, 32'(unlimited_depth_option_o));
    chk_val("record", 32'(RECORD_ALWAYS), 32'(record_control_o));
    pulse(arm_trigger_command_i);
    trigger_pin_i = 1'b1;
    run = 1'b1;
    wait_st(TRIG_IDLE, 800);
    chk_val("points", FIFO_DEPTH + 1, 32'(points_recorded_o));
    chk_val("full", 1, 32'(buffer_full_o));
    pulse(arm_trigger_command_i);
    chk_val("refused", 1, 32'(arm_refused_o));
    slow = 1'b1;
    stall = 1'b0;
    wait_got(5);
    stall = 1'b1;
    pulse(buffer_clear_i);
    @(negedge clk_i);
    chk_val("valid", 0, 32'(out_valid_o));
    chk_val("full", 0, 32'(buffer_full_o));
    cmp_q(5);
    pulse(arm_trigger_command_i);
    chk_val("state", 32'(TRIG_AWAIT), 32'(trig_state_o));
    $display("test fill and clear done");
    give_verdict();
  end
endmodule
